// ===== include/sse_pkg.sv
package sse_pkg;

    // =========================================================
    // Widths
    // =========================================================
    localparam int SSE_DATA_W = 8;
    localparam int SSE_OP_W   = 3;
    localparam int SSE_NIB_W  = 4;

    // =========================================================
    // Operation codes presented by the core decoder
    // =========================================================
    localparam logic [SSE_OP_W-1:0] SSE_OP_NOP       = 3'h0;
    localparam logic [SSE_OP_W-1:0] SSE_OP_SET_BIT   = 3'h1;
    localparam logic [SSE_OP_W-1:0] SSE_OP_INC_MEM   = 3'h2;
    localparam logic [SSE_OP_W-1:0] SSE_OP_INC_WORK  = 3'h3;
    localparam logic [SSE_OP_W-1:0] SSE_OP_BIT_SKIP  = 3'h4;
    localparam logic [SSE_OP_W-1:0] SSE_OP_SUB_WORK  = 3'h5;
    localparam logic [SSE_OP_W-1:0] SSE_OP_SUB_MEM   = 3'h6;
    localparam logic [SSE_OP_W-1:0] SSE_OP_SUB_IMM   = 3'h7;

    // =========================================================
    // Reset values and the increment constant
    // =========================================================
    localparam logic [SSE_DATA_W-1:0] SSE_WORK_RST = 8'h00;
    localparam logic [SSE_DATA_W-1:0] SSE_ONE      = 8'h01;
    localparam logic                  SSE_FLAG_RST = 1'b0;

    // =========================================================
    // Execution state: normal cycle or inserted dummy cycle
    // =========================================================
    typedef enum logic [1:0] {
        SSE_ST_EXEC  = 2'b01,
        SSE_ST_DUMMY = 2'b10
    } sse_state_t;

endpackage

// ===== rtl/sse_sub.sv
`timescale 1ns/1ns
module sse_sub #(
    parameter int DATA_W = sse_pkg::SSE_DATA_W
) (
    // Operands
    input  wire logic [DATA_W-1:0] minuend,
    input  wire logic [DATA_W-1:0] subtrahend,
    // Result and flags
    output logic      [DATA_W-1:0] diff,
    output logic                   carry,
    output logic                   half_borrow,
    output logic                   signed_wrap,
    output logic                   zero
);
    import sse_pkg::*;

    logic [DATA_W:0]    full_diff;
    logic [SSE_NIB_W:0] low_diff;

    generate
        if (DATA_W < SSE_NIB_W + 1) begin : g_bad_width
            $error("sse_sub: DATA_W too narrow for half borrow");
        end
    endgenerate

    // =========================================================
    // Carry is the inverse of borrow
    // =========================================================
    // RL8 carry as no-borrow
    always_comb begin
        full_diff   = {1'b0, minuend} - {1'b0, subtrahend};
        low_diff    = {1'b0, minuend[SSE_NIB_W-1:0]}
                    - {1'b0, subtrahend[SSE_NIB_W-1:0]};
        diff        = full_diff[DATA_W-1:0];
        carry       = ~full_diff[DATA_W];
        half_borrow = ~low_diff[SSE_NIB_W];
        signed_wrap = (minuend[DATA_W-1] ^ subtrahend[DATA_W-1])
                    & (minuend[DATA_W-1] ^ diff[DATA_W-1]);
        zero        = (diff == '0);
    end

endmodule

// ===== rtl/sse_exec.sv
`timescale 1ns/1ns
// Operation
// RL1 - Bit set forces chosen memory bit to one, flags untouched.
// RL2 - Memory increment writes byte plus one back; skips when zero.
// RL3 - Increment to work register leaves memory alone; skips when zero.
// RL4 - A taken skip inserts one dummy cycle, two cycles in all.
// RL5 - Bit test skips when chosen bit is one; no writes, no flags.
// RL6 - Work register minus memory into work register, four flags.
// RL7 - Work register minus memory into memory, same four flags.
// RL8 - Carry cleared on borrow, set when result zero or positive.
// RL9 - Immediate subtracted from work register, same carry convention.
// RL10 - Results wrap at eight bits; skipped instruction has no effect.
module sse_exec #(
    parameter int DATA_W = sse_pkg::SSE_DATA_W
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // Decoded instruction from the core
    input  wire logic                          op_valid,
    input  wire logic [sse_pkg::SSE_OP_W-1:0]  op_code,
    input  wire logic [$clog2(DATA_W)-1:0]     bit_sel,
    input  wire logic [DATA_W-1:0]             imm_data,
    input  wire logic [DATA_W-1:0]             mem_rd_data,
    output logic                               op_ready,
    // Data memory write-back
    output logic                               mem_wr_en,
    output logic      [DATA_W-1:0]             mem_wr_data,
    // Architectural state
    output logic      [DATA_W-1:0]             work_register,
    output logic                               carry_flag,
    output logic                               half_borrow_flag,
    output logic                               zero_flag,
    output logic                               signed_wrap_flag,
    // Skip pipeline control
    output logic                               dummy_cycle
);
    import sse_pkg::*;

    sse_state_t        state_reg;
    sse_state_t        state_next;
    logic [DATA_W-1:0] work_reg;
    logic [DATA_W-1:0] work_next;
    logic [3:0]        flag_reg;
    logic [3:0]        flag_next;
    logic              mem_wr_en_reg;
    logic              mem_wr_en_next;
    logic [DATA_W-1:0] mem_wr_data_reg;
    logic [DATA_W-1:0] mem_wr_data_next;

    logic              op_fire;
    logic [DATA_W-1:0] inc_val;
    logic [DATA_W-1:0] bit_mask;
    logic              bit_hit;
    logic [DATA_W-1:0] sub_rhs;
    logic [DATA_W-1:0] sub_diff;
    logic              sub_carry;
    logic              sub_half;
    logic              sub_wrap;
    logic              sub_zero;

    generate
        if (DATA_W < SSE_DATA_W) begin : g_bad_width
            $error("sse_exec: DATA_W below 8 is not supported");
        end
        // Bit index must reach every bit and no more
        if (DATA_W != (1 << $clog2(DATA_W))) begin : g_bad_pow2
            $error("sse_exec: DATA_W must be a power of two");
        end
    endgenerate

    // =========================================================
    // Operand preparation
    // =========================================================
    assign op_fire  = op_valid && (state_reg == SSE_ST_EXEC);
    // RL10 eight bit wrap
    assign inc_val  = DATA_W'(mem_rd_data + SSE_ONE);
    assign bit_mask = DATA_W'(SSE_ONE) << bit_sel;
    assign bit_hit  = mem_rd_data[bit_sel];
    // RL9 immediate operand select
    assign sub_rhs  = (op_code == SSE_OP_SUB_IMM) ? imm_data : mem_rd_data;

    sse_sub #(
        .DATA_W      (DATA_W)
    ) u_sub (
        .minuend     (work_reg),
        .subtrahend  (sub_rhs),
        .diff        (sub_diff),
        .carry       (sub_carry),
        .half_borrow (sub_half),
        .signed_wrap (sub_wrap),
        .zero        (sub_zero)
    );

    // =========================================================
    // Next-state logic
    // =========================================================
    always_comb begin
        state_next       = SSE_ST_EXEC;
        work_next        = work_reg;
        flag_next        = flag_reg;
        mem_wr_en_next   = 1'b0;
        mem_wr_data_next = mem_wr_data_reg;
        case (state_reg)
            SSE_ST_EXEC: begin
                if (op_valid) begin
                    case (op_code)
                        // RL1 bit set
                        SSE_OP_SET_BIT: begin
                            mem_wr_en_next   = 1'b1;
                            mem_wr_data_next = mem_rd_data | bit_mask;
                        end
                        // RL2 memory increment
                        SSE_OP_INC_MEM: begin
                            mem_wr_en_next   = 1'b1;
                            mem_wr_data_next = inc_val;
                            if (inc_val == '0) begin
                                state_next = SSE_ST_DUMMY;
                            end
                        end
                        // RL3 increment into work
                        SSE_OP_INC_WORK: begin
                            work_next = inc_val;
                            if (inc_val == '0) begin
                                state_next = SSE_ST_DUMMY;
                            end
                        end
                        // RL5 bit test skip
                        SSE_OP_BIT_SKIP: begin
                            if (bit_hit) begin
                                state_next = SSE_ST_DUMMY;
                            end
                        end
                        // RL6 RL9 subtract into work
                        SSE_OP_SUB_WORK, SSE_OP_SUB_IMM: begin
                            work_next = sub_diff;
                            flag_next = {sub_wrap, sub_zero,
                                         sub_half, sub_carry};
                        end
                        // RL7 subtract into memory
                        SSE_OP_SUB_MEM: begin
                            mem_wr_en_next   = 1'b1;
                            mem_wr_data_next = sub_diff;
                            flag_next = {sub_wrap, sub_zero,
                                         sub_half, sub_carry};
                        end
                        default: begin
                            mem_wr_en_next = 1'b0;
                        end
                    endcase
                end
            end
            // RL4 RL10 dummy cycle swallows skipped instruction
            SSE_ST_DUMMY: begin
                state_next = SSE_ST_EXEC;
            end
            default: begin
                state_next = SSE_ST_EXEC;
            end
        endcase
    end

    // =========================================================
    // State registers
    // =========================================================
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg       <= SSE_ST_EXEC;
            work_reg        <= DATA_W'(SSE_WORK_RST);
            flag_reg        <= {4{SSE_FLAG_RST}};
            mem_wr_en_reg   <= 1'b0;
            mem_wr_data_reg <= DATA_W'(SSE_WORK_RST);
        end else begin
            state_reg       <= state_next;
            work_reg        <= work_next;
            flag_reg        <= flag_next;
            mem_wr_en_reg   <= mem_wr_en_next;
            mem_wr_data_reg <= mem_wr_data_next;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    // Ready drops in the dummy cycle so the core holds the next fetch
    assign op_ready         = (state_reg == SSE_ST_EXEC);
    assign dummy_cycle      = (state_reg == SSE_ST_DUMMY);
    assign mem_wr_en        = mem_wr_en_reg;
    assign mem_wr_data      = mem_wr_data_reg;
    assign work_register    = work_reg;
    assign carry_flag       = flag_reg[0];
    assign half_borrow_flag = flag_reg[1];
    assign zero_flag        = flag_reg[2];
    assign signed_wrap_flag = flag_reg[3];

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_set_bit_only: assert property ( // RL1
        op_fire && op_code == SSE_OP_SET_BIT |=> mem_wr_en
        && mem_wr_data == ($past(mem_rd_data) | $past(bit_mask))
        && $stable(flag_reg) && !dummy_cycle)
        else $error("bit set wrote wrong value or touched flags");

    a_inc_mem_wr: assert property ( // RL2
        op_fire && op_code == SSE_OP_INC_MEM |=> mem_wr_en
        && mem_wr_data == $past(inc_val)
        && dummy_cycle == (mem_wr_data == '0) && $stable(flag_reg))
        else $error("memory increment result or skip wrong");

    a_inc_work_only: assert property ( // RL3
        op_fire && op_code == SSE_OP_INC_WORK |=> !mem_wr_en
        && work_reg == $past(inc_val)
        && dummy_cycle == (work_reg == '0) && $stable(flag_reg))
        else $error("work increment result or skip wrong");

    a_skip_two_cycle: assert property ( // RL4
        op_fire && state_next == SSE_ST_DUMMY
        |=> dummy_cycle && !op_ready ##1 op_ready)
        else $error("skip did not take exactly one dummy cycle");

    a_bit_test_skip: assert property ( // RL5
        op_fire && op_code == SSE_OP_BIT_SKIP |=> !mem_wr_en
        && dummy_cycle == $past(bit_hit)
        && $stable(work_reg) && $stable(flag_reg))
        else $error("bit test skip decision wrong");

    a_sub_work_res: assert property ( // RL6
        op_fire && op_code == SSE_OP_SUB_WORK |=> !mem_wr_en
        && work_reg == DATA_W'($past(work_reg) - $past(mem_rd_data))
        && zero_flag == (work_reg == '0))
        else $error("register subtract result wrong");

    a_sub_mem_res: assert property ( // RL7
        op_fire && op_code == SSE_OP_SUB_MEM |=> mem_wr_en
        && mem_wr_data == DATA_W'($past(work_reg) - $past(mem_rd_data))
        && $stable(work_reg) && zero_flag == (mem_wr_data == '0))
        else $error("memory subtract result wrong");

    a_carry_borrow: assert property ( // RL8
        op_fire && (op_code == SSE_OP_SUB_WORK
        || op_code == SSE_OP_SUB_MEM || op_code == SSE_OP_SUB_IMM)
        |=> carry_flag == ($past(work_reg) >= $past(sub_rhs)))
        else $error("carry does not follow borrow convention");

    a_sub_imm_res: assert property ( // RL9
        op_fire && op_code == SSE_OP_SUB_IMM |=> !mem_wr_en
        && work_reg == DATA_W'($past(work_reg) - $past(imm_data)))
        else $error("immediate subtract result wrong");

    a_skip_quiet: assert property ( // RL10
        dummy_cycle |=> !mem_wr_en && $stable(work_reg)
        && $stable(flag_reg) && !dummy_cycle)
        else $error("skipped instruction had a side effect");

    c_inc_wrap_skip: cover property (
        op_fire && op_code == SSE_OP_INC_MEM && mem_rd_data == '1
        ##1 dummy_cycle);
    c_bit_skip: cover property (
        op_fire && op_code == SSE_OP_BIT_SKIP && bit_hit ##1 dummy_cycle);
    c_sub_borrow: cover property (
        op_fire && op_code == SSE_OP_SUB_MEM ##1 !carry_flag);
    c_sub_overflow: cover property (
        op_fire && op_code == SSE_OP_SUB_IMM ##1 signed_wrap_flag);

endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ns
module tb;
    import sse_pkg::*;

    // =========================================================
    // Stimulus and design outputs
    // =========================================================
    logic                  clk_sys     = 1'b0;
    logic                  rst         = 1'b1;
    logic                  op_valid    = 1'b0;
    logic [SSE_OP_W-1:0]   op_code     = SSE_OP_NOP;
    logic [2:0]            bit_sel     = 3'h0;
    logic [SSE_DATA_W-1:0] imm_data    = 8'h00;
    logic [SSE_DATA_W-1:0] mem_rd_data = 8'h00;
    logic                  op_ready;
    logic                  mem_wr_en;
    logic [SSE_DATA_W-1:0] mem_wr_data;
    logic [SSE_DATA_W-1:0] work_register;
    logic                  carry_flag;
    logic                  half_borrow_flag;
    logic                  zero_flag;
    logic                  signed_wrap_flag;
    logic                  dummy_cycle;
    int                    fail_count  = 0;
    int                    check_count = 0;
    int                    cycles      = 0;
    int                    seed        = 32'had38_4b6b;
    logic [31:0]           rv;

    always #2 clk_sys = ~clk_sys;

    sse_exec #(.DATA_W(SSE_DATA_W)) uut (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .op_valid         (op_valid),
        .op_code          (op_code),
        .bit_sel          (bit_sel),
        .imm_data         (imm_data),
        .mem_rd_data      (mem_rd_data),
        .op_ready         (op_ready),
        .mem_wr_en        (mem_wr_en),
        .mem_wr_data      (mem_wr_data),
        .work_register    (work_register),
        .carry_flag       (carry_flag),
        .half_borrow_flag (half_borrow_flag),
        .zero_flag        (zero_flag),
        .signed_wrap_flag (signed_wrap_flag),
        .dummy_cycle      (dummy_cycle)
    );

    // =========================================================
    // Cycle model, integer arithmetic
    // =========================================================
    int e_work, e_wdata, e_wen, e_dummy, e_c, e_h, e_z, e_v;
    int m, r, ws, ms;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {e_work, e_wdata, e_wen, e_dummy} = '0;
            {e_c, e_h, e_z, e_v} = '0;
        end else begin
            e_wen = 0;
            m = mem_rd_data;
            // Skipped slot: whatever is offered is dropped
            if (e_dummy != 0) begin
                e_dummy = 0;
            end else if (op_valid === 1'b1) begin
                case (op_code)
                    SSE_OP_SET_BIT: begin
                        e_wen = 1;
                        e_wdata = m | (1 << bit_sel);
                    end
                    SSE_OP_INC_MEM: begin
                        e_wen = 1;
                        e_wdata = (m + 1) % 256;
                        e_dummy = (e_wdata == 0);
                    end
                    SSE_OP_INC_WORK: begin
                        e_work = (m + 1) % 256;
                        e_dummy = (e_work == 0);
                    end
                    SSE_OP_BIT_SKIP: e_dummy = (m >> bit_sel) & 1;
                    SSE_OP_SUB_WORK, SSE_OP_SUB_MEM, SSE_OP_SUB_IMM: begin
                        if (op_code == SSE_OP_SUB_IMM) m = imm_data;
                        r = e_work - m;
                        ws = e_work - ((e_work > 127) ? 256 : 0);
                        ms = m - ((m > 127) ? 256 : 0);
                        e_c = (r >= 0);
                        e_h = ((e_work % 16) >= (m % 16));
                        e_z = ((r & 255) == 0);
                        e_v = ((ws - ms) > 127) || ((ws - ms) < -128);
                        if (op_code == SSE_OP_SUB_MEM) begin
                            e_wen = 1;
                            e_wdata = r & 255;
                        end else begin
                            e_work = r & 255;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // =========================================================
    // Comparison and closing
    // =========================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(negedge clk_sys) begin
        chk(work_register, 8'(e_work));
        chk({7'h00, mem_wr_en}, 8'(e_wen));
        chk(mem_wr_data, 8'(e_wdata));
        chk({4'h0, carry_flag, half_borrow_flag, zero_flag,
             signed_wrap_flag}, 8'(e_c * 8 + e_h * 4 + e_z * 2 + e_v));
        chk({6'h00, op_ready, dummy_cycle}, 8'((e_dummy != 0) ? 1 : 2));
    end

    // Hang guard: run needs about 3025 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= 10000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic drive(input logic v, input logic [2:0] op,
                         input logic [2:0] b, input logic [7:0] imm,
                         input logic [7:0] mem);
        @(posedge clk_sys);
        op_valid    <= v;
        op_code     <= op;
        bit_sel     <= b;
        imm_data    <= imm;
        mem_rd_data <= mem;
    endtask

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        drive(1'b1, SSE_OP_SUB_IMM, 3'h0, 8'hfb, 8'h00);
        drive(1'b1, SSE_OP_SUB_WORK, 3'h0, 8'h00, 8'h07);
        drive(1'b1, SSE_OP_INC_MEM, 3'h0, 8'h00, 8'hff);
        drive(1'b1, SSE_OP_SUB_IMM, 3'h0, 8'h01, 8'h00);
        drive(1'b1, SSE_OP_SET_BIT, 3'h3, 8'h00, 8'h00);
        drive(1'b1, SSE_OP_BIT_SKIP, 3'h7, 8'h00, 8'h80);
        drive(1'b1, SSE_OP_SET_BIT, 3'h0, 8'h00, 8'h00);
        drive(1'b1, SSE_OP_BIT_SKIP, 3'h7, 8'h00, 8'h7f);
        drive(1'b1, SSE_OP_INC_WORK, 3'h0, 8'h00, 8'hff);
        drive(1'b1, SSE_OP_SUB_MEM, 3'h0, 8'h00, 8'h00);
        drive(1'b1, SSE_OP_SUB_MEM, 3'h0, 8'h00, 8'h00);
        drive(1'b1, SSE_OP_SUB_IMM, 3'h0, 8'h80, 8'h00);
        drive(1'b1, SSE_OP_INC_WORK, 3'h0, 8'h00, 8'h04);
        for (int i = 0; i < 3000; i++) begin
            rv = $random(seed);
            drive(rv[24:22] != 3'h0, rv[18:16], rv[21:19], rv[15:8],
                  (rv[31:30] == 2'h0) ? 8'hff : rv[7:0]);
            // Mid-run reset lands with instructions in flight
            if (i == 1500) begin
                rst <= 1'b1;
                @(posedge clk_sys);
                // Nothing offered on the release edge itself
                op_valid <= 1'b0;
                @(posedge clk_sys);
                rst <= 1'b0;
            end
        end
        drive(1'b0, SSE_OP_NOP, 3'h0, 8'h00, 8'h00);
        repeat (3) @(posedge clk_sys);
        finish_test();
    end
endmodule
